/* rtl/monitor_limit_flags.sv */
// Purpose: Compare three analog input results against 16-bit limits and keep the alarm and warning flags.
// Assumes: Converter results and memory accesses arrive on i_clk; no synchroniser needed.
// Notes:   Limit shadow copies reset to the factory value; nonvolatile backing lives outside.
`timescale 1ns/100ps

module monitor_limit_flags
	import limit_flags_pkg::*;
(
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_arst_n,
	// Converter results
	input  wire meas_t      i_meas_a,
	input  wire meas_t      i_meas_b,
	input  wire meas_t      i_meas_c,
	// Memory map byte access
	input  wire mem_req_t   i_mem,
	output logic [7:0]      o_mem_rdata,
	output logic            o_mem_rvalid,
	// Flag bytes
	output logic [7:0]      o_alarm_ab,
	output logic [7:0]      o_alarm_c,
	output logic [7:0]      o_warn_ab
);

	logic [15:0] limit_r [LIMIT_COUNT];   // Shadow copies of the limit words
	logic [15:0] meas_r  [3];             // Stored results a, b, c
	logic [7:0]  alarm_ab_r;              // Flag byte 70h
	logic [7:0]  alarm_c_r;               // Flag byte 71h
	logic [7:0]  warn_ab_r;               // Flag byte 74h
	logic [7:0]  rdata_nxt;               // Read mux result

	// Limit slot of an address, or LIMIT_COUNT when outside the limit area.
	// The limit area is contiguous, so one subtract and one shift find the slot.
	function automatic int limit_slot(input logic [7:0] addr);
		int slot;
		slot = LIMIT_COUNT;
		if (addr >= OFS_A_HI_ALARM && addr < OFS_A_HI_ALARM + 8'(2 * LIMIT_COUNT)) begin
			slot = int'((addr - OFS_A_HI_ALARM) >> 1);
		end
		return slot;
	endfunction

	// New flag value; equality leaves the flag as it was.
	// high_side picks whether rising above or falling below sets the flag.
	function automatic logic flag_upd(input logic cur, input logic high_side,
	                                  input logic [15:0] val, input logic [15:0] lim);
		logic res;
		res = cur;
		if (val > lim) begin
			res = high_side;
		end else if (val < lim) begin
			res = !high_side;
		end
		return res;
	endfunction

	// Limit writes: even address is the high byte, odd the low byte.
	// Each byte lands on its own edge, so a result stored between the two
	// writes of one word meets a half-updated limit; software that cares
	// writes the word while that input is quiet.
	// Reset brings every shadow copy back to the factory value, since the
	// nonvolatile backing copy is kept outside this block.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			for (int i = 0; i < LIMIT_COUNT; i++) begin
				limit_r[i] <= LIMIT_FACTORY;
			end
		end else if (i_mem.wr && limit_slot(i_mem.addr) < LIMIT_COUNT) begin
			if (!i_mem.addr[0]) begin
				limit_r[limit_slot(i_mem.addr)][15:8] <= i_mem.wdata;
			end else begin
				limit_r[limit_slot(i_mem.addr)][7:0] <= i_mem.wdata;
			end
		end
	end

	// Result words are volatile and written only by the converter.
	// Bus writes to these addresses never reach here, so the words
	// always read back exactly what was last measured.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			meas_r[0] <= MEAS_RESET;
			meas_r[1] <= MEAS_RESET;
			meas_r[2] <= MEAS_RESET;
		end else begin
			if (i_meas_a.valid) begin
				meas_r[0] <= i_meas_a.value;
			end
			if (i_meas_b.valid) begin
				meas_r[1] <= i_meas_b.value;
			end
			if (i_meas_c.valid) begin
				meas_r[2] <= i_meas_c.value;
			end
		end
	end

	// Flags follow the result as it is stored, against the limits as they stand now.
	// Comparing the incoming value saves a cycle of flag latency over using meas_r.
	// A limit write in the same cycle as a result is seen only by the next result,
	// and a limit change alone never moves a flag: only a fresh result re-evaluates.
	// Spare bits of the flag bytes stay at their reset value.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			alarm_ab_r <= FLAGS_RESET;
			alarm_c_r  <= FLAGS_RESET;
			warn_ab_r  <= FLAGS_RESET;
		end else begin
			// Input a owns bits 3 and 2 of the alarm and warning bytes
			if (i_meas_a.valid) begin
				alarm_ab_r[BIT_A_HI] <= flag_upd(alarm_ab_r[BIT_A_HI], 1'b1, i_meas_a.value, limit_r[0]);
				alarm_ab_r[BIT_A_LO] <= flag_upd(alarm_ab_r[BIT_A_LO], 1'b0, i_meas_a.value, limit_r[1]);
				warn_ab_r[BIT_A_HI]  <= flag_upd(warn_ab_r[BIT_A_HI], 1'b1, i_meas_a.value, limit_r[2]);
				warn_ab_r[BIT_A_LO]  <= flag_upd(warn_ab_r[BIT_A_LO], 1'b0, i_meas_a.value, limit_r[3]);
			end
			// Input b owns bits 1 and 0 of the alarm and warning bytes
			if (i_meas_b.valid) begin
				alarm_ab_r[BIT_B_HI] <= flag_upd(alarm_ab_r[BIT_B_HI], 1'b1, i_meas_b.value, limit_r[4]);
				alarm_ab_r[BIT_B_LO] <= flag_upd(alarm_ab_r[BIT_B_LO], 1'b0, i_meas_b.value, limit_r[5]);
				warn_ab_r[BIT_B_HI]  <= flag_upd(warn_ab_r[BIT_B_HI], 1'b1, i_meas_b.value, limit_r[6]);
				warn_ab_r[BIT_B_LO]  <= flag_upd(warn_ab_r[BIT_B_LO], 1'b0, i_meas_b.value, limit_r[7]);
			end
			// Input c owns bits 7 and 6 of its own alarm byte
			if (i_meas_c.valid) begin
				alarm_c_r[BIT_C_HI] <= flag_upd(alarm_c_r[BIT_C_HI], 1'b1, i_meas_c.value, limit_r[8]);
				alarm_c_r[BIT_C_LO] <= flag_upd(alarm_c_r[BIT_C_LO], 1'b0, i_meas_c.value, limit_r[9]);
			end
		end
	end

	// Read decode; unmapped and reserved bytes read as zero.
	// Reads have no side effect, so a read and a write in one cycle
	// return the byte as it stood before the write.
	// Result and flag bytes are read-only: writes to them fall through.
	always_comb begin
		rdata_nxt = UNMAPPED_READ;
		if (limit_slot(i_mem.addr) < LIMIT_COUNT) begin
			rdata_nxt = i_mem.addr[0] ? limit_r[limit_slot(i_mem.addr)][7:0]
			                          : limit_r[limit_slot(i_mem.addr)][15:8];
		end else if (i_mem.addr == OFS_MEAS_A || i_mem.addr == OFS_MEAS_A + 8'h01) begin
			rdata_nxt = i_mem.addr[0] ? meas_r[0][7:0] : meas_r[0][15:8];
		end else if (i_mem.addr == OFS_MEAS_B || i_mem.addr == OFS_MEAS_B + 8'h01) begin
			rdata_nxt = i_mem.addr[0] ? meas_r[1][7:0] : meas_r[1][15:8];
		end else if (i_mem.addr == OFS_MEAS_C || i_mem.addr == OFS_MEAS_C + 8'h01) begin
			rdata_nxt = i_mem.addr[0] ? meas_r[2][7:0] : meas_r[2][15:8];
		end else if (i_mem.addr == OFS_ALARM_AB) begin
			rdata_nxt = alarm_ab_r;
		end else if (i_mem.addr == OFS_ALARM_C) begin
			rdata_nxt = alarm_c_r;
		end else if (i_mem.addr == OFS_WARN_AB) begin
			rdata_nxt = warn_ab_r;
		end
	end

	// Registered read answer, one cycle after the request.
	// The data holds until the next read, so a slow master may fetch it late;
	// the valid pulse lasts one cycle only.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_mem_rdata  <= UNMAPPED_READ;
			o_mem_rvalid <= 1'b0;
		end else begin
			o_mem_rvalid <= i_mem.rd;
			if (i_mem.rd) begin
				o_mem_rdata <= rdata_nxt;
			end
		end
	end

	// Flag bytes leave straight from their registers
	assign o_alarm_ab = alarm_ab_r;
	assign o_alarm_c  = alarm_c_r;
	assign o_warn_ab  = warn_ab_r;

	// Checks
	// All of them run on i_clk and rest while reset is asserted,
	// so the first edge after release already sees reset values in $past.
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	// High byte write, one quiet bus cycle, then a read of the same byte
	sequence hi_write_s;
		i_mem.wr && !i_mem.addr[0] && i_mem.addr == OFS_A_HI_ALARM && !i_mem.rd;
	endsequence
	sequence bus_quiet_s;
		!i_mem.wr;
	endsequence
	sequence rd_back_s;
		i_mem.rd && !i_mem.wr && i_mem.addr == OFS_A_HI_ALARM;
	endsequence

	limit_hi_byte_a: assert property (hi_write_s ##1 bus_quiet_s ##1 rd_back_s
		|=> o_mem_rdata == $past(i_mem.wdata, 3))
		else $error("limit high byte readback wrong");
	limit_write_now_a: assert property (i_mem.wr && i_mem.addr == OFS_A_LO_ALARM + 8'h01
		|=> limit_r[1][7:0] == $past(i_mem.wdata))
		else $error("limit low byte not updated");
	a_hi_alarm_a: assert property (i_meas_a.valid && i_meas_a.value > limit_r[0] |=> alarm_ab_r[3])
		else $error("input a high alarm not set");
	a_lo_alarm_a: assert property (i_meas_a.valid && i_meas_a.value > limit_r[1] |=> !alarm_ab_r[2])
		else $error("input a low alarm not cleared");
	a_hi_warn_a: assert property (i_meas_a.valid && i_meas_a.value < limit_r[2] |=> !warn_ab_r[3])
		else $error("input a high warning not cleared");
	a_lo_warn_a: assert property (i_meas_a.valid && i_meas_a.value < limit_r[3] |=> warn_ab_r[2])
		else $error("input a low warning not set");
	b_hi_alarm_a: assert property (i_meas_b.valid && i_meas_b.value > limit_r[4] |=> alarm_ab_r[1])
		else $error("input b high alarm not set");
	b_lo_alarm_a: assert property (i_meas_b.valid && i_meas_b.value < limit_r[5] |=> alarm_ab_r[0])
		else $error("input b low alarm not set");
	b_hi_warn_a: assert property (i_meas_b.valid && i_meas_b.value > limit_r[6] |=> warn_ab_r[1])
		else $error("input b high warning not set");
	b_lo_warn_a: assert property (i_meas_b.valid && i_meas_b.value > limit_r[7] |=> !warn_ab_r[0])
		else $error("input b low warning not cleared");
	c_hi_alarm_a: assert property (i_meas_c.valid && i_meas_c.value > limit_r[8] |=> alarm_c_r[7])
		else $error("input c high alarm not set");
	c_lo_alarm_a: assert property (i_meas_c.valid && i_meas_c.value < limit_r[9] |=> alarm_c_r[6])
		else $error("input c low alarm not set");
	meas_store_a: assert property (i_meas_b.valid |=> meas_r[1] == $past(i_meas_b.value))
		else $error("input b result not stored");
	equal_hold_a: assert property (i_meas_a.valid && i_meas_a.value == limit_r[0]
		|=> $stable(alarm_ab_r[3]))
		else $error("flag moved on equal result");
	idle_hold_a: assert property (!i_meas_c.valid |=> $stable(alarm_c_r))
		else $error("input c flags moved without a result");

	// Read answers come exactly one cycle after the request
	read_answer_a: assert property (i_mem.rd |=> o_mem_rvalid)
		else $error("read answer missing");
	no_stray_answer_a: assert property (!i_mem.rd |=> !o_mem_rvalid)
		else $error("read answer without a request");
	rdata_hold_a: assert property (!i_mem.rd |=> $stable(o_mem_rdata))
		else $error("read data moved without a read");

	// Each byte of a limit updates alone, with no atomic pairing
	hi_byte_alone_a: assert property (i_mem.wr && i_mem.addr == OFS_A_HI_ALARM
		|=> limit_r[0][15:8] == $past(i_mem.wdata) && $stable(limit_r[0][7:0]))
		else $error("limit high byte write went wrong");
	lo_byte_alone_a: assert property (i_mem.wr && i_mem.addr == OFS_A_LO_ALARM + 8'h01
		|=> $stable(limit_r[1][15:8]))
		else $error("limit high byte moved on a low byte write");
	limit_read_a: assert property (i_mem.rd && i_mem.addr == OFS_C_LO_ALARM + 8'h01
		|=> o_mem_rdata == $past(limit_r[9][7:0]))
		else $error("limit low byte read wrong");

	// Shadow copies hold while no write arrives
	limit_hold_a: assert property (!i_mem.wr |=> $stable(limit_r[0]) && $stable(limit_r[9]))
		else $error("limit moved without a write");

	// Result words change only on a converter strobe; bus writes cannot reach them
	a_result_hold_a: assert property (!i_meas_a.valid |=> $stable(meas_r[0]))
		else $error("input a result moved without a strobe");
	c_result_read_a: assert property (i_mem.rd && i_mem.addr == OFS_MEAS_C
		|=> o_mem_rdata == $past(meas_r[2][15:8]))
		else $error("input c result high byte read wrong");

	// Flag bytes read back as they stood at the request
	alarm_read_a: assert property (i_mem.rd && i_mem.addr == OFS_ALARM_AB
		|=> o_mem_rdata == $past(alarm_ab_r))
		else $error("alarm byte of inputs a and b read wrong");
	alarm_c_read_a: assert property (i_mem.rd && i_mem.addr == OFS_ALARM_C
		|=> o_mem_rdata == $past(alarm_c_r))
		else $error("alarm byte of input c read wrong");
	warn_read_a: assert property (i_mem.rd && i_mem.addr == OFS_WARN_AB
		|=> o_mem_rdata == $past(warn_ab_r))
		else $error("warning byte read wrong");

	// Spare flag bits never rise
	ab_spare_zero_a: assert property (alarm_ab_r[7:4] == 4'h0 && warn_ab_r[7:4] == 4'h0)
		else $error("spare bit set in an input a and b flag byte");
	c_spare_zero_a: assert property (alarm_c_r[5:0] == 6'h00)
		else $error("spare bit set in the input c alarm byte");

	// Equal results keep the flag on every input, for a low alarm, a high alarm and a low warning
	b_equal_hold_a: assert property (i_meas_b.valid && i_meas_b.value == limit_r[5]
		|=> $stable(alarm_ab_r[0]))
		else $error("input b low alarm moved on equal result");
	c_equal_hold_a: assert property (i_meas_c.valid && i_meas_c.value == limit_r[8]
		|=> $stable(alarm_c_r[7]))
		else $error("input c high alarm moved on equal result");
	warn_equal_hold_a: assert property (i_meas_a.valid && i_meas_a.value == limit_r[3]
		|=> $stable(warn_ab_r[2]))
		else $error("input a low warning moved on equal result");

	// Flags of inputs a and b stay put with no result for them
	ab_idle_hold_a: assert property (!i_meas_a.valid && !i_meas_b.valid
		|=> $stable(alarm_ab_r) && $stable(warn_ab_r))
		else $error("input a or b flags moved without a result");

endmodule

/* rtl/limit_flags_pkg.sv */
// Purpose: Shared constants and types for the monitor limit flag block.
// Assumes: Byte-wide internal memory map behind the two-wire serial port.
// Notes:   Offsets are byte addresses of the lower memory page.
package limit_flags_pkg;

	// Threshold words, high byte at the even address
	localparam logic [7:0]  OFS_A_HI_ALARM   = 8'h10;
	localparam logic [7:0]  OFS_A_LO_ALARM   = 8'h12;
	localparam logic [7:0]  OFS_A_HI_WARN    = 8'h14;
	localparam logic [7:0]  OFS_A_LO_WARN    = 8'h16;
	localparam logic [7:0]  OFS_B_HI_ALARM   = 8'h18;
	localparam logic [7:0]  OFS_B_LO_ALARM   = 8'h1a;
	localparam logic [7:0]  OFS_B_HI_WARN    = 8'h1c;
	localparam logic [7:0]  OFS_B_LO_WARN    = 8'h1e;
	localparam logic [7:0]  OFS_C_HI_ALARM   = 8'h20;
	localparam logic [7:0]  OFS_C_LO_ALARM   = 8'h22;
	localparam int          LIMIT_COUNT      = 10;

	// Measurement words and flag bytes
	localparam logic [7:0]  OFS_MEAS_A       = 8'h64;
	localparam logic [7:0]  OFS_MEAS_B       = 8'h66;
	localparam logic [7:0]  OFS_MEAS_C       = 8'h68;
	localparam logic [7:0]  OFS_ALARM_AB     = 8'h70;
	localparam logic [7:0]  OFS_ALARM_C      = 8'h71;
	localparam logic [7:0]  OFS_WARN_AB      = 8'h74;

	// Flag bit positions
	localparam int          BIT_A_HI         = 3;
	localparam int          BIT_A_LO         = 2;
	localparam int          BIT_B_HI         = 1;
	localparam int          BIT_B_LO         = 0;
	localparam int          BIT_C_HI         = 7;
	localparam int          BIT_C_LO         = 6;

	// Reset values
	localparam logic [15:0] LIMIT_FACTORY    = 16'h0000;
	localparam logic [15:0] MEAS_RESET       = 16'h0000;
	localparam logic [7:0]  FLAGS_RESET      = 8'h00;
	localparam logic [7:0]  UNMAPPED_READ    = 8'h00;

	// One converter result with its store strobe
	typedef struct packed {
		logic        valid;
		logic [15:0] value;
	} meas_t;

	// Byte access to the memory map
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} mem_req_t;

endpackage

/* testbench/analog_inputs_model.sv */
// Purpose: Far side stand-in for the three analog inputs and their converter.
// Assumes: The bench launches one result request 1 ns after a rising edge.
// Notes:   Idle value lines show the inverse of the last result, so stale data cannot pass.
`timescale 1ns/100ps
module analog_inputs_model
	import limit_flags_pkg::*;
(
	// Clock and request
	input  wire logic        i_clk,
	input  wire logic        i_go,
	input  wire logic [1:0]  i_sel,
	input  wire logic [15:0] i_value,
	// Results toward the block
	output meas_t            o_meas [3]
);
	logic [15:0] last_r [3];	// Last result per input

	// Strobe only the selected input, scramble the others
	always_comb begin
		for (int k = 0; k < 3; k++) begin
			o_meas[k].valid = i_go && (i_sel == 2'(k));
			o_meas[k].value = (i_go && (i_sel == 2'(k))) ? i_value : ~last_r[k];
		end
	end

	// Remember what each input last delivered
	always_ff @(posedge i_clk) begin
		for (int k = 0; k < 3; k++) begin
			if (i_go && (i_sel == 2'(k))) begin
				last_r[k] <= i_value;
			end
		end
	end
endmodule

/* testbench/monitor_limit_flags_test.sv */
// Purpose: Self-checking bench for the limit flag block.
// Assumes: Requests start 1 ns after a rising edge; tasks start and end there.
// Notes:   Expected flags come from a reference of the compare rules, never from outputs.
`timescale 1ns/100ps
module monitor_limit_flags_test import limit_flags_pkg::*;;
	logic        i_clk;
	logic        i_arst_n;
	mem_req_t    i_mem;
	logic [7:0]  o_mem_rdata;
	logic        o_mem_rvalid;
	logic [7:0]  o_alarm_ab;
	logic [7:0]  o_alarm_c;
	logic [7:0]  o_warn_ab;
	meas_t       meas [3];
	logic        go;
	logic [1:0]  sel;
	logic [15:0] value;
	int          mismatches;
	int          total_checks;
	logic [15:0] lim [LIMIT_COUNT];	// Limits as programmed
	logic [15:0] last_v [3];	// Last result per input
	logic [7:0]  exp_f [3];	// Expected 70h, 71h, 74h
	// Limit table: offset, input, flag byte, flag bit; even entries are high limits
	localparam logic [7:0] OFS [LIMIT_COUNT] = '{OFS_A_HI_ALARM, OFS_A_LO_ALARM, OFS_A_HI_WARN,
		OFS_A_LO_WARN, OFS_B_HI_ALARM, OFS_B_LO_ALARM, OFS_B_HI_WARN, OFS_B_LO_WARN, OFS_C_HI_ALARM, OFS_C_LO_ALARM};
	localparam int CH [LIMIT_COUNT] = '{0, 0, 0, 0, 1, 1, 1, 1, 2, 2};
	localparam int FB [LIMIT_COUNT] = '{0, 0, 2, 2, 0, 0, 2, 2, 1, 1};
	localparam int BT [LIMIT_COUNT] = '{BIT_A_HI, BIT_A_LO, BIT_A_HI, BIT_A_LO, BIT_B_HI, BIT_B_LO,
		BIT_B_HI, BIT_B_LO, BIT_C_HI, BIT_C_LO};
	// Below, equal, above, equal, below: equal must keep the previous flag
	localparam logic [15:0] STEP [5] = '{16'hffff, 16'h0000, 16'h0001, 16'h0000, 16'hffff};

	monitor_limit_flags DUT (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_meas_a(meas[0]), .i_meas_b(meas[1]),
		.i_meas_c(meas[2]), .i_mem(i_mem), .o_mem_rdata(o_mem_rdata), .o_mem_rvalid(o_mem_rvalid),
		.o_alarm_ab(o_alarm_ab), .o_alarm_c(o_alarm_c), .o_warn_ab(o_warn_ab));
	analog_inputs_model inputs (.i_clk(i_clk), .i_go(go), .i_sel(sel), .i_value(value), .o_meas(meas));

	// 25 MHz clock
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end

	task automatic check(string what, logic [7:0] exp, logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One byte write, taken at the next edge; an idle edge follows so requests never abut
	task automatic mem_wr(logic [7:0] a, logic [7:0] d);
		i_mem = {1'b1, 1'b0, a, d};
		@(posedge i_clk);
		#1 i_mem = '0;
		@(posedge i_clk);
		#1;
	endtask

	// One byte read; the answer is awaited under a bound
	task automatic mem_rd(logic [7:0] a, logic [7:0] exp, string what);
		i_mem = {1'b0, 1'b1, a, 8'h00};
		@(posedge i_clk);
		#1 i_mem = '0;
		for (int n = 0; n < 4 && o_mem_rvalid !== 1'b1; n++) begin
			@(posedge i_clk);
			#1;
		end
		check("read valid", 8'h01, {7'h00, o_mem_rvalid});
		check(what, exp, o_mem_rdata);
		@(posedge i_clk);
		#1;
	endtask

	// One result on input c, then all three flag bytes against the reference
	task automatic send(int c, logic [15:0] v);
		sel = 2'(c);
		value = v;
		go = 1'b1;
		@(posedge i_clk);
		#1 go = 1'b0;
		last_v[c] = v;
		for (int i = 0; i < LIMIT_COUNT; i++) begin
			if (CH[i] == c && ((i % 2 == 0) ? v > lim[i] : v < lim[i])) exp_f[FB[i]][BT[i]] = 1'b1;
			if (CH[i] == c && ((i % 2 == 0) ? v < lim[i] : v > lim[i])) exp_f[FB[i]][BT[i]] = 1'b0;
		end
		check("alarm_ab", exp_f[0], o_alarm_ab);
		check("alarm_c", exp_f[1], o_alarm_c);
		check("warn_ab", exp_f[2], o_warn_ab);
		@(posedge i_clk);
		#1;
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		i_arst_n = 1'b0;
		i_mem = '0;
		go = 1'b0;
		sel = 2'h0;
		value = 16'h0000;
		mismatches = 0;
		total_checks = 0;
		exp_f = '{default: 8'h00};
		repeat (8) @(posedge i_clk);
		#1 i_arst_n = 1'b1;
		check("reset alarm_ab", FLAGS_RESET, o_alarm_ab);
		check("reset alarm_c", FLAGS_RESET, o_alarm_c);
		check("reset warn_ab", FLAGS_RESET, o_warn_ab);
		check("reset rdata", UNMAPPED_READ, o_mem_rdata);
		check("reset rvalid", 8'h00, {7'h00, o_mem_rvalid});
		// Factory zero, then program and read back both bytes of every limit
		for (int i = 0; i < LIMIT_COUNT; i++) begin
			lim[i] = {8'h40 + 8'(i * 16), 8'h03 + 8'(i)};
			mem_rd(OFS[i], LIMIT_FACTORY[15:8], "factory high byte");
			mem_rd(OFS[i] + 8'h01, LIMIT_FACTORY[7:0], "factory low byte");
			mem_wr(OFS[i] + 8'h01, lim[i][7:0]);
			mem_wr(OFS[i], lim[i][15:8]);
			mem_rd(OFS[i], lim[i][15:8], "limit high byte");
			mem_rd(OFS[i] + 8'h01, lim[i][7:0], "limit low byte");
		end
		// Walk each limit from below through equal to above and back
		for (int i = 0; i < LIMIT_COUNT; i++) begin
			foreach (STEP[s]) send(CH[i], lim[i] + STEP[s]);
		end
		// A lone low byte write moves the limit at once
		lim[0][7:0] = lim[0][7:0] + 8'h20;
		mem_wr(OFS_A_HI_ALARM + 8'h01, lim[0][7:0]);
		send(0, lim[0] + 16'h0001);
		send(0, lim[0] - 16'h0001);
		// Stored results, high byte first; result high bytes and flag byte 70h refuse writes
		for (int c = 0; c < 3; c++) begin
			mem_wr(OFS_MEAS_A + 8'(2 * c), ~last_v[c][15:8]);
			mem_rd(OFS_MEAS_A + 8'(2 * c), last_v[c][15:8], "result high byte");
			mem_rd(OFS_MEAS_A + 8'(2 * c + 1), last_v[c][7:0], "result low byte");
		end
		mem_wr(OFS_ALARM_AB, ~exp_f[0]);
		mem_rd(OFS_ALARM_AB, exp_f[0], "alarm byte 70h");
		mem_rd(OFS_ALARM_C, exp_f[1], "alarm byte 71h");
		mem_rd(OFS_WARN_AB, exp_f[2], "warning byte 74h");
		mem_rd(8'h30, UNMAPPED_READ, "unmapped byte");
		wrap_up();
	end

	// Hang guard
	initial begin
		repeat (20000) @(posedge i_clk);
		mismatches++;
		$display("wrong value run length expected end seen timeout");
		wrap_up();
	end
endmodule
